// File: rtl/isca_top.sv
// indirect access port: AXI4-Lite data and command registers driving the fabric
// Operation
// - data read returns fabric value when read flag set, else last written value
// - writing one to bit 31 starts the selected fabric access
// - pending flag holds until the access completes, then clears itself
// - bit 30 selects direction: 0 write, 1 read
// - step-up: data write launches access, index increments after the write
// - step-up: data read increments index and launches the next access
// - step-down: data write launches access, index decrements after the write
// - step-down: data read decrements index and launches the next access
// - step-up wins when step-up and step-down are both set
// - lane select bits 19:16 gate fabric write bytes
// - lane bit 3 covers data 31:24 down to lane bit 0 for 7:0
// - bits 15:0 hold the 16-bit fabric target index
// - after reset data reads zero and all command fields are zero
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
module isca_top
  import isca_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   fab_req,
  output logic                   fab_we,
  output logic [INDEX_W-1:0]     fab_addr,
  output logic [31:0]            fab_wdata,
  output logic [LANE_W-1:0]      fab_be,
  input  wire logic [31:0]       fab_rdata,
  input  wire logic              fab_ack
);
  typedef struct packed {
    logic               rnw;
    logic               inc;
    logic               dec;
    logic [LANE_W-1:0]  lane;
    logic [INDEX_W-1:0] index;
    logic               pending;
    logic               post_step;
    logic [31:0]        wr_val;
    logic [31:0]        rd_val;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
  } isca_state_s;

  isca_state_s s;
  isca_state_s s_nxt;

  logic              pair_valid;
  logic [AXI_AW-1:0] pair_addr;
  logic [31:0]       pair_data;
  logic [3:0]        pair_strb;
  logic              take;
  logic              ar_take;
  logic              w_go;
  logic              r_go;
  logic              start;
  logic              seq_done;
  logic [31:0]       seq_data;
  logic [31:0]       cmd_new;

  // command register image as software sees it
  function automatic logic [31:0] cmd_word(input isca_state_s st);
    logic [31:0] w;
    w                         = '0;
    w[BUSY_BIT]               = st.pending;
    w[RNW_BIT]                = st.rnw;
    w[INC_BIT]                = st.inc;
    w[DEC_BIT]                = st.dec;
    w[LANE_LSB +: LANE_W]     = st.lane;
    w[INDEX_LSB +: INDEX_W]   = st.index;
    return w;
  endfunction

  isca_wjoin u_wjoin
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .awaddr     (s_axi_awaddr),
    .awvalid    (s_axi_awvalid),
    .awready    (s_axi_awready),
    .wdata      (s_axi_wdata),
    .wstrb      (s_axi_wstrb),
    .wvalid     (s_axi_wvalid),
    .wready     (s_axi_wready),
    .take       (take),
    .pair_valid (pair_valid),
    .pair_addr  (pair_addr),
    .pair_data  (pair_data),
    .pair_strb  (pair_strb)
  );

  isca_fabseq u_fabseq
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .start      (start),
    .start_we   (!s_nxt.rnw),
    .start_addr (s_nxt.index),
    .start_data (s_nxt.wr_val),
    .start_be   (s_nxt.lane),
    .fab_req    (fab_req),
    .fab_we     (fab_we),
    .fab_addr   (fab_addr),
    .fab_wdata  (fab_wdata),
    .fab_be     (fab_be),
    .fab_rdata  (fab_rdata),
    .fab_ack    (fab_ack),
    .done       (seq_done),
    .done_data  (seq_data)
  );

  always_comb
  begin
    s_nxt   = s;
    cmd_new = isca_merge(cmd_word(s), pair_data, pair_strb);
    take    = pair_valid && !s.bvalid;
    ar_take = s_axi_arvalid && s.arready;
    w_go    = 1'b0;
    r_go    = 1'b0;

    if (seq_done)
    begin
      s_nxt.pending = 1'b0;
      if (!fab_we)
        s_nxt.rd_val = seq_data;
      // index moves only after the write has finished
      if (s.post_step)
      begin
        s_nxt.index     = isca_step(s.index, s.inc);
        s_nxt.post_step = 1'b0;
      end
    end

    if (take)
    begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = RESP_OKAY;
      if (pair_addr == DATA_OFS)
      begin
        // writes during an access are dropped, not queued
        if (!s.pending)
        begin
          s_nxt.wr_val = isca_merge(s.wr_val, pair_data, pair_strb);
          if (s.inc || s.dec)
          begin
            w_go            = 1'b1;
            s_nxt.post_step = !s.rnw;
          end
        end
      end
      else if (pair_addr == CMD_OFS)
      begin
        if (!s.pending)
        begin
          // field capture; reserved bits never stored
          s_nxt.rnw   = cmd_new[RNW_BIT];
          s_nxt.inc   = cmd_new[INC_BIT];
          s_nxt.dec   = cmd_new[DEC_BIT];
          s_nxt.lane  = cmd_new[LANE_LSB +: LANE_W];
          s_nxt.index = cmd_new[INDEX_LSB +: INDEX_W];
          // one written to busy starts; zero has no effect
          w_go        = cmd_new[BUSY_BIT];
        end
      end
      else
      begin
        s_nxt.bresp = RESP_SLVERR;
      end
    end

    if (s.bvalid && s_axi_bready)
      s_nxt.bvalid = 1'b0;

    if (ar_take)
    begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid  = 1'b1;
      s_nxt.rresp   = RESP_OKAY;
      if (s_axi_araddr == DATA_OFS)
      begin
        s_nxt.rdata = s.rnw ? s.rd_val : s.wr_val;
        // stepping read; a write launch this cycle wins
        if ((s.inc || s.dec) && !s.pending && !w_go)
        begin
          r_go        = 1'b1;
          s_nxt.index = isca_step(s.index, s.inc);
        end
      end
      else if (s_axi_araddr == CMD_OFS)
      begin
        s_nxt.rdata = cmd_word(s);
      end
      else
      begin
        s_nxt.rdata = '0;
        s_nxt.rresp = RESP_SLVERR;
      end
    end

    if (s.rvalid && s_axi_rready)
    begin
      s_nxt.rvalid  = 1'b0;
      s_nxt.arready = 1'b1;
    end

    start = w_go || r_go;
    if (start)
      s_nxt.pending = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s         <= '0;
      s.arready <= 1'b1;
    end
    else if (ce)
    begin
      s <= s_nxt;
    end
  end

  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;

  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_busy_holds: assert property (s.pending && !(ce && seq_done) |=> s.pending)
    else $error("pending cleared before completion");

  a_busy_clears: assert property (ce && seq_done |=> !s.pending)
    else $error("pending not cleared after completion");

  a_cmd_launch: assert property (ce && take && pair_addr == CMD_OFS && !s.pending
                                 && pair_strb[3] && pair_data[BUSY_BIT]
                                 |=> s.pending && fab_req && fab_addr == s.index)
    else $error("command write with busy did not launch");

  a_dir_select: assert property (fab_req |-> fab_we == !s.rnw)
    else $error("fabric direction differs from read flag");

  a_lane_gate: assert property (fab_req && fab_we |-> fab_be == s.lane
                                && fab_wdata == s.wr_val)
    else $error("fabric write lanes or data wrong");

  a_data_source: assert property (ce && ar_take && s_axi_araddr == DATA_OFS
                                  |=> s_axi_rvalid && s_axi_rdata ==
                                  ($past(s.rnw) ? $past(s.rd_val) : $past(s.wr_val)))
    else $error("data read returned wrong source");

  a_up_read: assert property (ce && ar_take && s_axi_araddr == DATA_OFS && s.inc
                              && !s.pending && !w_go
                              |=> s.pending && s.index == 16'($past(s.index) + 16'h0001))
    else $error("step-up read did not advance");

  a_down_read: assert property (ce && ar_take && s_axi_araddr == DATA_OFS && s.dec
                                && !s.inc && !s.pending && !w_go
                                |=> s.pending && s.index == 16'($past(s.index) - 16'h0001))
    else $error("step-down read did not retreat");

  a_up_priority: assert property (ce && ar_take && s_axi_araddr == DATA_OFS && s.inc
                                  && s.dec && !s.pending && !w_go
                                  |=> s.index == 16'($past(s.index) + 16'h0001))
    else $error("step-down applied while step-up set");

  a_write_step: assert property (ce && take && pair_addr == DATA_OFS && !s.pending
                                 && s.inc && !s.rnw
                                 |=> s.pending && s.post_step && fab_req
                                 && fab_addr == $past(s.index))
    else $error("step write launch or index wrong");

  a_step_after: assert property (ce && seq_done && s.post_step && !s.inc
                                 |=> s.index == 16'($past(s.index) - 16'h0001))
    else $error("index not stepped after write");

  a_rsv_zero: assert property (ce && ar_take && s_axi_araddr == CMD_OFS
                               |=> s_axi_rdata[RSV_LSB +: RSV_W] == 8'h00
                               && s_axi_rdata[INDEX_LSB +: INDEX_W] == $past(s.index))
    else $error("command read image wrong");

  a_req_stable: assert property (fab_req && !fab_ack |=> fab_req && $stable(fab_addr)
                                 && $stable(fab_we) && $stable(fab_be) && $stable(fab_wdata))
    else $error("fabric request changed before ack");

  a_req_drops: assert property (ce && fab_req && fab_ack |=> !fab_req)
    else $error("fabric request held after ack");

  a_cmd_fields: assert property (ce && take && pair_addr == CMD_OFS && !s.pending
                                 && pair_strb == 4'hf && !ar_take
                                 |=> s.index == $past(pair_data[INDEX_LSB +: INDEX_W])
                                 && s.lane == $past(pair_data[LANE_LSB +: LANE_W]))
    else $error("command fields not captured");

  a_read_store: assert property (ce && seq_done && !fab_we
                                 |=> s.rd_val == $past(fab_rdata))
    else $error("fabric read value not stored");

  a_up_write: assert property (ce && seq_done && s.post_step && s.inc
                               |=> s.index == 16'($past(s.index) + 16'h0001))
    else $error("index not stepped up after write");

  a_busy_image: assert property (ce && ar_take && s_axi_araddr == CMD_OFS
                                 |=> s_axi_rdata[BUSY_BIT] == $past(s.pending))
    else $error("pending flag image wrong");
endmodule

// File: rtl/isca_pkg.sv
// package: offsets, field layout, reset values and helpers of the indirect access port
package isca_pkg;
  localparam int          AXI_AW      = 12;
  localparam logic [11:0] DATA_OFS    = 12'h1ac;
  localparam logic [11:0] CMD_OFS     = 12'h1b0;
  localparam int          BUSY_BIT    = 31;
  localparam int          RNW_BIT     = 30;
  localparam int          INC_BIT     = 29;
  localparam int          DEC_BIT     = 28;
  localparam int          RSV_LSB     = 20;
  localparam int          RSV_W       = 8;
  localparam int          LANE_LSB    = 16;
  localparam int          LANE_W      = 4;
  localparam int          INDEX_LSB   = 0;
  localparam int          INDEX_W     = 16;
  localparam logic [31:0] DATA_RST    = 32'h0000_0000;
  localparam logic [3:0]  LANE_RST    = 4'h0;
  localparam logic [15:0] INDEX_RST   = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // byte-wise overlay of new data on old, one strobe bit per byte
  function automatic logic [31:0] isca_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // next target index; 16-bit wrap is intended
  function automatic logic [15:0] isca_step(input logic [15:0] idx,
                                            input logic        up);
    return up ? 16'(idx + 16'h0001) : 16'(idx - 16'h0001);
  endfunction
endpackage

// File: rtl/isca_wjoin.sv
// write address and write data capture, joined into one register write
`timescale 1ns/100ps
module isca_wjoin
  import isca_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic              take,
  output logic                   pair_valid,
  output logic [AXI_AW-1:0]      pair_addr,
  output logic [31:0]            pair_data,
  output logic [3:0]             pair_strb
);
  typedef struct packed {
    logic              has_aw;
    logic              has_w;
    logic              aw_rdy;
    logic              w_rdy;
    logic [AXI_AW-1:0] addr;
    logic [31:0]       data;
    logic [3:0]        strb;
  } isca_wjoin_s;

  localparam isca_wjoin_s JOIN_RST = '{1'b0, 1'b0, 1'b1, 1'b1, '0, '0, '0};

  isca_wjoin_s s_r;
  isca_wjoin_s s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (take)
    begin
      s_nxt.has_aw = 1'b0;
      s_nxt.has_w  = 1'b0;
    end
    if (awvalid && s_r.aw_rdy)
    begin
      s_nxt.has_aw = 1'b1;
      s_nxt.addr   = awaddr;
    end
    if (wvalid && s_r.w_rdy)
    begin
      s_nxt.has_w = 1'b1;
      s_nxt.data  = wdata;
      s_nxt.strb  = wstrb;
    end
    // ready as a flop keeps the top outputs registered
    s_nxt.aw_rdy = !s_nxt.has_aw;
    s_nxt.w_rdy  = !s_nxt.has_w;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_r <= JOIN_RST;
    else if (ce)
      s_r <= s_nxt;
  end

  assign awready    = s_r.aw_rdy;
  assign wready     = s_r.w_rdy;
  assign pair_valid = s_r.has_aw && s_r.has_w;
  assign pair_addr  = s_r.addr;
  assign pair_data  = s_r.data;
  assign pair_strb  = s_r.strb;
endmodule

// File: rtl/isca_fabseq.sv
// fabric side sequencer: one request held until the fabric acknowledges it
`timescale 1ns/100ps
module isca_fabseq
  import isca_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  input  wire logic               start,
  input  wire logic               start_we,
  input  wire logic [INDEX_W-1:0] start_addr,
  input  wire logic [31:0]        start_data,
  input  wire logic [LANE_W-1:0]  start_be,
  output logic                    fab_req,
  output logic                    fab_we,
  output logic [INDEX_W-1:0]      fab_addr,
  output logic [31:0]             fab_wdata,
  output logic [LANE_W-1:0]       fab_be,
  input  wire logic [31:0]        fab_rdata,
  input  wire logic               fab_ack,
  output logic                    done,
  output logic [31:0]             done_data
);
  typedef enum logic {SEQ_IDLE, SEQ_WAIT} isca_seq_e;

  typedef struct packed {
    isca_seq_e          st;
    logic               we;
    logic [INDEX_W-1:0] addr;
    logic [31:0]        data;
    logic [LANE_W-1:0]  be;
  } isca_seq_s;

  isca_seq_s s_r;
  isca_seq_s s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    unique case (s_r.st)
      SEQ_IDLE:
      begin
        if (start)
        begin
          s_nxt.st   = SEQ_WAIT;
          s_nxt.we   = start_we;
          s_nxt.addr = start_addr;
          s_nxt.data = start_data;
          s_nxt.be   = start_be;
        end
      end
      SEQ_WAIT:
      begin
        if (fab_ack)
          s_nxt.st = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_r <= '{SEQ_IDLE, 1'b0, INDEX_RST, DATA_RST, LANE_RST};
    else if (ce)
      s_r <= s_nxt;
  end

  assign fab_req   = (s_r.st == SEQ_WAIT);
  assign fab_we    = s_r.we;
  assign fab_addr  = s_r.addr;
  assign fab_wdata = s_r.data;
  assign fab_be    = s_r.be;
  // ack ignored outside a request; no reply can land in idle
  assign done      = (s_r.st == SEQ_WAIT) && fab_ack;
  assign done_data = fab_rdata;
endmodule

// File: sim/isca_fab_model.sv
// fabric register file model answering the indirect access port
`timescale 1ns/100ps
module isca_fab_model
  import isca_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [7:0]         lat,
  input  wire logic               fab_req,
  input  wire logic               fab_we,
  input  wire logic [INDEX_W-1:0] fab_addr,
  input  wire logic [31:0]        fab_wdata,
  input  wire logic [LANE_W-1:0]  fab_be,
  output logic [31:0]             fab_rdata,
  output logic                    fab_ack
);
  logic [31:0] mem [0:255];
  logic [7:0]  wait_cnt;

  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      mem[i] = 32'hc300_0000 ^ (i * 32'h0001_0203);
    end
    fab_rdata = 32'h0000_0000;
    fab_ack   = 1'b0;
    wait_cnt  = 8'h00;
  end

  always @(posedge aclk)
  begin
    fab_ack   <= 1'b0;
    // only meaningful with ack, so keep it moving otherwise
    fab_rdata <= ~fab_rdata;
    if (!aresetn)
    begin
      wait_cnt <= 8'h00;
    end
    else if (fab_req && !fab_ack)
    begin
      if (wait_cnt + 8'h01 >= lat)
      begin
        wait_cnt <= 8'h00;
        fab_ack  <= 1'b1;
        if (fab_we)
        begin
          for (int b = 0; b < 4; b++)
          begin
            if (fab_be[b])
              mem[fab_addr[7:0]][b*8 +: 8] <= fab_wdata[b*8 +: 8];
          end
        end
        else
          fab_rdata <= mem[fab_addr[7:0]];
      end
      else
        wait_cnt <= wait_cnt + 8'h01;
    end
  end
endmodule

// File: sim/tb.sv
// testbench: AXI4-Lite register sequences against the indirect access port
`timescale 1ns/100ps
module tb
  import isca_pkg::*;
();
  localparam logic [31:0] BUSY  = 32'h8000_0000;
  localparam logic [31:0] RNW   = 32'h4000_0000;
  localparam logic [31:0] INC   = 32'h2000_0000;
  localparam logic [31:0] DEC   = 32'h1000_0000;
  localparam logic [31:0] LANES = 32'h000f_0000;

  logic              aclk;
  logic              aresetn;
  logic              ce;
  logic [11:0]       s_axi_awaddr;
  logic              s_axi_awvalid;
  logic              s_axi_awready;
  logic [31:0]       s_axi_wdata;
  logic [3:0]        s_axi_wstrb;
  logic              s_axi_wvalid;
  logic              s_axi_wready;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_bvalid;
  logic              s_axi_bready;
  logic [11:0]       s_axi_araddr;
  logic              s_axi_arvalid;
  logic              s_axi_arready;
  logic [31:0]       s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic              s_axi_rvalid;
  logic              s_axi_rready;
  logic              fab_req;
  logic              fab_we;
  logic [15:0]       fab_addr;
  logic [31:0]       fab_wdata;
  logic [3:0]        fab_be;
  logic [31:0]       fab_rdata;
  logic              fab_ack;
  logic [7:0]        lat;
  logic [31:0]       shadow [0:255];
  logic [31:0]       v;
  logic [31:0]       e;
  logic [31:0]       mode;
  logic [15:0]       idx;
  logic [3:0]        be;
  logic [1:0]        r;
  int                err_count;
  int                checks_done;

  isca_top dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fab_req(fab_req),
    .fab_we(fab_we), .fab_addr(fab_addr), .fab_wdata(fab_wdata), .fab_be(fab_be),
    .fab_rdata(fab_rdata), .fab_ack(fab_ack));

  isca_fab_model fab_u (.aclk(aclk), .aresetn(aresetn), .lat(lat), .fab_req(fab_req),
    .fab_we(fab_we), .fab_addr(fab_addr), .fab_wdata(fab_wdata), .fab_be(fab_be),
    .fab_rdata(fab_rdata), .fab_ack(fab_ack));

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic guard(inout int n);
    n++;
    if (n > 400)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: wait bound exhausted", $time);
      report_and_stop();
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      guard(n);
    end
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
      guard(n);
    end
  endtask

  // polls pending; only reads the command register meanwhile
  task automatic wait_idle();
    logic [31:0] c;
    logic [1:0]  rs;
    int          n;
    n = 0;
    do
    begin
      axi_rd(CMD_OFS, c, rs);
      guard(n);
    end
    while (c[BUSY_BIT] !== 1'b0);
  endtask

  task automatic shadow_wr(input logic [15:0] i, input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++)
    begin
      if (s[b])
        shadow[i[7:0]][b*8 +: 8] = d[b*8 +: 8];
    end
  endtask

  initial
  begin
    err_count = 0;
    checks_done = 0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    aresetn = 1'b0;
    ce = 1'b1;
    lat = 8'h01;
    for (int i = 0; i < 256; i++)
      shadow[i] = 32'hc300_0000 ^ (i * 32'h0001_0203);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(DATA_OFS, v, r);
    chk(v, DATA_RST, "data after reset"); // data zero
    axi_rd(CMD_OFS, v, r);
    chk(v, 32'h0000_0000, "command after reset"); // fields zero
    axi_rd(12'h1b4, v, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    axi_wr(12'h1a8, 32'hffff_ffff, 4'hf, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    for (int i = 0; i < 5; i++)
    begin
      be = (i < 4) ? 4'(1 << i) : 4'ha;
      idx = 16'h0010 + 16'(i);
      e = 32'h1122_3344 + 32'(i);
      lat <= 8'(i + 1);
      axi_wr(DATA_OFS, e, 4'hf, r);
      axi_wr(CMD_OFS, BUSY | {12'h000, be, idx}, 4'hf, r); // launch write
      chk({30'h0, r}, {30'h0, RESP_OKAY}, "write okay"); // command accepted
      wait_idle(); // completion awaited
      shadow_wr(idx, e, be);
      chk(fab_u.mem[idx[7:0]], shadow[idx[7:0]], "lane write"); // byte lanes
      axi_rd(DATA_OFS, v, r);
      chk(v, e, "last written value"); // write direction readback
    end
    lat <= 8'h14;
    axi_wr(CMD_OFS, BUSY | RNW | 32'h0ff0_0033, 4'hf, r);
    axi_rd(CMD_OFS, v, r);
    chk(v, BUSY | RNW | 32'h0000_0033, "pending held"); // held, reserved zero
    ce <= 1'b0;
    repeat (40) @(posedge aclk);
    chk({31'h0, fab_req}, 32'h0000_0001, "frozen request"); // frozen access holds
    ce <= 1'b1;
    wait_idle();
    axi_rd(CMD_OFS, v, r);
    chk(v, RNW | 32'h0000_0033, "pending cleared"); // self clear
    axi_rd(DATA_OFS, v, r);
    chk(v, shadow[8'h33], "fabric read"); // fabric value
    for (int m = 0; m < 3; m++)
    begin
      mode = (m == 0) ? INC : ((m == 1) ? DEC : (INC | DEC));
      idx = (m == 0) ? 16'hfffe : ((m == 1) ? 16'h0001 : 16'h0040);
      lat <= 8'(m + 2);
      axi_wr(CMD_OFS, mode | LANES | {16'h0000, idx}, 4'hf, r); // all lanes
      for (int k = 0; k < 3; k++)
      begin
        e = 32'hd000_0000 | {16'h0000, idx};
        axi_wr(DATA_OFS, e, 4'hf, r); // write launches
        wait_idle();
        shadow_wr(idx, e, 4'hf);
        chk(fab_u.mem[idx[7:0]], e, "stepped write"); // run write
        idx = (m == 1) ? 16'(idx - 16'h0001) : 16'(idx + 16'h0001);
      end
      axi_rd(CMD_OFS, v, r);
      chk(v, mode | LANES | {16'h0000, idx}, "stepped index"); // index step
    end
    for (int m = 0; m < 2; m++)
    begin
      mode = m ? DEC : INC;
      idx = 16'h0080;
      lat <= 8'h03;
      axi_wr(CMD_OFS, BUSY | RNW | mode | LANES | {16'h0000, idx}, 4'hf, r);
      wait_idle();
      for (int k = 0; k < 2; k++)
      begin
        axi_rd(DATA_OFS, v, r);
        chk(v, shadow[idx[7:0]], "stepped read"); // value before step
        idx = m ? 16'(idx - 16'h0001) : 16'(idx + 16'h0001);
        wait_idle();
      end
      axi_rd(CMD_OFS, v, r);
      chk(v, RNW | mode | LANES | {16'h0000, idx}, "read step index"); // index moved
      axi_wr(CMD_OFS, RNW | LANES | {16'h0000, idx}, 4'hf, r); // stepping off
      axi_rd(DATA_OFS, v, r);
      chk(v, shadow[idx[7:0]], "final read"); // launched read
      axi_rd(CMD_OFS, v, r);
      chk(v, RNW | LANES | {16'h0000, idx}, "no launch"); // no further access
    end
    report_and_stop();
  end
endmodule
